// *** include/pdcr_pkg.sv ***
// Shared constants for the power capability report block
package pdcr_pkg;

    // Capability type codes placed in byte 2 of each capability descriptor; last, the descriptor type for byte 1
    localparam logic [7:0] PDCR_CODE_PD_CAP      = 8'h06;
    localparam logic [7:0] PDCR_CODE_BATTERY     = 8'h07;
    localparam logic [7:0] PDCR_CODE_SINK_PORT   = 8'h08;
    localparam logic [7:0] PDCR_CODE_SOURCE_PORT = 8'h09;
    localparam logic [7:0] PDCR_DESC_DEVCAP_TYPE = 8'h10;

    // Descriptor layout of the capability descriptor
    localparam logic [7:0] PDCR_PD_CAP_LEN  = 8'h18;
    localparam logic [7:0] PDCR_SUB_LEN     = 8'h08;
    localparam logic [7:0] PDCR_SET_TYPE    = 8'h0f;
    localparam logic [7:0] PDCR_SET_HDR_LEN = 8'h05;
    localparam int         PDCR_OFS_LEN     = 0;
    localparam int         PDCR_OFS_TYPE    = 1;
    localparam int         PDCR_OFS_CODE    = 2;
    localparam int         PDCR_OFS_ATTR    = 4;

    // Attribute bitmap field positions
    localparam int PDCR_ATTR_BC       = 1;
    localparam int PDCR_ATTR_PD       = 2;
    localparam int PDCR_ATTR_PROVIDER = 3;
    localparam int PDCR_ATTR_CONSUMER = 4;
    localparam int PDCR_ATTR_CHG_POL  = 5;
    localparam int PDCR_ATTR_TYPEC    = 6;
    localparam logic [31:0] PDCR_ATTR_RSVD_MASK = 32'hffff_ff81;

    // Status request selectors
    localparam logic [1:0] PDCR_SEL_SET    = 2'h0;
    localparam logic [1:0] PDCR_SEL_STATUS = 2'h1;
    localparam logic [1:0] PDCR_SEL_PORT   = 2'h2;

    // Policy modes
    localparam logic [1:0] PDCR_MODE_LOCAL     = 2'h0;
    localparam logic [1:0] PDCR_MODE_HYBRID    = 2'h1;
    localparam logic [1:0] PDCR_MODE_INTRUSIVE = 2'h2;

    // Notification ids sent over the hub notification endpoint
    localparam logic [7:0] PDCR_NOTE_CONTRACT = 8'h01;
    localparam logic [7:0] PDCR_NOTE_PORT     = 8'h02;

    // Usb device states seen by this block
    typedef enum logic [2:0] {
        PDCR_ST_ATTACHED,
        PDCR_ST_POWERED,
        PDCR_ST_DEFAULT,
        PDCR_ST_ADDRESS,
        PDCR_ST_CONFIGURED
    } pdcr_state_type;

    // Byte server states
    typedef enum logic [1:0] {
        PDCR_RD_IDLE,
        PDCR_RD_SEND,
        PDCR_RD_DONE
    } pdcr_rd_type;

endpackage

// *** rtl/pdcr_sync.sv ***
// Three flop synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module pdcr_sync
    import pdcr_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             clk_sys_in,
    input  wire logic             nrst_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    initial
    begin
        if (WIDTH < 1)
            $error("pdcr_sync width must be positive");
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else if (ce_in)
        begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A change counts only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            always_ff @(posedge clk_sys_in or negedge nrst_in)
            begin
                if (!nrst_in)
                    level_out[gi] <= 1'b0;
                else if (ce_in && (s2_q[gi] == s3_q[gi]))
                    level_out[gi] <= s3_q[gi];
            end
        end
    endgenerate

endmodule

// *** rtl/pdcr_top.sv ***
// Power capability descriptor report and attach state logic
`timescale 1ns/1ps
module pdcr_top
    import pdcr_pkg::*;
#(
    parameter bit       IS_HUB        = 1'b1,
    parameter bit       HAS_HYBRID    = 1'b0,
    parameter bit       HAS_INTRUSIVE = 1'b0,
    parameter int       NUM_PORTS     = 4,
    parameter bit       HAS_BATTERY   = 1'b1,
    parameter bit       CAN_PROVIDE   = 1'b0,
    parameter bit       CAN_CONSUME   = 1'b1,
    parameter bit       SUPPORTS_BC   = 1'b1,
    parameter bit       SUPPORTS_TYPEC = 1'b1
)
(
    input  wire logic                 clk_sys_in,
    input  wire logic                 nrst_in,
    input  wire logic                 ce_in,
    // Power delivery side, from pins
    input  wire logic                 vbus_present_in,
    input  wire logic                 contract_ok_in,
    input  wire logic                 can_operate_in,
    input  wire logic                 role_swap_in,
    input  wire logic                 hard_reset_in,
    // Usb core side, same clock
    input  wire logic                 bus_reset_in,
    input  wire logic                 addressed_in,
    input  wire logic                 configured_in,
    input  wire logic                 req_valid_in,
    input  wire logic [1:0]           req_sel_in,
    input  wire logic [7:0]           req_index_in,
    input  wire logic [1:0]           policy_mode_in,
    input  wire logic [NUM_PORTS-1:0] port_pd_in,
    input  wire logic                 note_ready_in,
    output logic                      connect_out,
    output logic                      self_powered_out,
    output logic [2:0]                usb_state_out,
    output logic                      rsp_valid_out,
    output logic [7:0]                rsp_data_out,
    output logic                      rsp_last_out,
    output logic                      rsp_stall_out,
    output logic [1:0]                policy_mode_out,
    output logic                      note_valid_out,
    output logic [7:0]                note_data_out
);

    localparam int PW = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;

    initial
    begin
        if (NUM_PORTS < 1 || NUM_PORTS > 15)
            $error("pdcr_top NUM_PORTS must be 1 to 15");
    end

    logic [4:0]     pins;
    logic           vbus;
    logic           contract;
    logic           operate;
    logic           swap;
    logic           hreset;
    pdcr_state_type state_q;
    pdcr_rd_type    rd_q;
    logic [7:0]     len_q;
    logic [7:0]     ptr_q;
    logic [1:0]     sel_q;
    logic [7:0]     idx_q;
    logic           contract_q;
    logic [NUM_PORTS-1:0] port_q;

    pdcr_sync #(
        .WIDTH (5)
    ) u_sync (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .ce_in      (ce_in),
        .async_in   ({vbus_present_in, contract_ok_in, can_operate_in,
                      role_swap_in, hard_reset_in}),
        .level_out  (pins)
    );

    assign vbus     = pins[4];
    assign contract = pins[3];
    assign operate  = pins[2];
    assign swap     = pins[1];
    assign hreset   = pins[0];

    // Attribute bitmap; reserved bits forced low by mask
    function automatic logic [31:0] attr_bits();
        logic [31:0] a;
        a = '0;
        a[PDCR_ATTR_BC]       = SUPPORTS_BC;
        a[PDCR_ATTR_PD]       = 1'b1;
        a[PDCR_ATTR_PROVIDER] = CAN_PROVIDE;
        a[PDCR_ATTR_CONSUMER] = CAN_CONSUME;
        a[PDCR_ATTR_CHG_POL]  = 1'b0;
        a[PDCR_ATTR_TYPEC]    = SUPPORTS_TYPEC;
        return a & ~PDCR_ATTR_RSVD_MASK;
    endfunction

    // Byte n of the object store set: header, then capability, then
    // one short record each for sink port, source port and, with HAS_BATTERY, battery
    function automatic logic [7:0] set_byte(input logic [7:0] n);
        logic [31:0] a;
        logic [7:0]  sub;
        logic [7:0]  o;
        a = attr_bits();
        sub = PDCR_SUB_LEN;
        set_byte = 8'h00;
        if (n < PDCR_SET_HDR_LEN)
        begin
            case (n)
                8'h00: set_byte = PDCR_SET_HDR_LEN;
                8'h01: set_byte = PDCR_SET_TYPE;
                8'h02: set_byte = total_len();
                8'h04: set_byte = 8'h02 + {7'h0, HAS_BATTERY};
                default: set_byte = 8'h00;
            endcase
        end
        else
        begin
            o = n - PDCR_SET_HDR_LEN;
            if (o < PDCR_PD_CAP_LEN)
            begin
                if (o == 8'(PDCR_OFS_LEN))
                    set_byte = PDCR_PD_CAP_LEN;
                else if (o == 8'(PDCR_OFS_TYPE))
                    set_byte = PDCR_DESC_DEVCAP_TYPE;
                else if (o == 8'(PDCR_OFS_CODE))
                    set_byte = PDCR_CODE_PD_CAP;
                else if (o >= 8'(PDCR_OFS_ATTR) && o < 8'(PDCR_OFS_ATTR + 4))
                    set_byte = a[8*(o-8'(PDCR_OFS_ATTR)) +: 8];
            end
            else
            begin
                o = o - PDCR_PD_CAP_LEN;
                if (o[2:0] == 3'(PDCR_OFS_LEN))
                    set_byte = sub;
                else if (o[2:0] == 3'(PDCR_OFS_TYPE))
                    set_byte = PDCR_DESC_DEVCAP_TYPE;
                else if (o[2:0] == 3'(PDCR_OFS_CODE))
                begin
                    if (o[7:3] == 5'h0)
                        set_byte = PDCR_CODE_SINK_PORT;
                    else if (o[7:3] == 5'h1)
                        set_byte = PDCR_CODE_SOURCE_PORT;
                    else
                        set_byte = PDCR_CODE_BATTERY;
                end
            end
        end
    endfunction

    function automatic logic [7:0] total_len();
        return PDCR_SET_HDR_LEN + PDCR_PD_CAP_LEN
               + 8'(2 * PDCR_SUB_LEN)
               + (HAS_BATTERY ? PDCR_SUB_LEN : 8'h00);
    endfunction

    // Device state: attached/powered by contract, rest by usb core
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            state_q <= PDCR_ST_ATTACHED;
        else if (ce_in)
        begin
            if (CAN_CONSUME && !vbus && !((swap || hreset) && operate))
                state_q <= PDCR_ST_ATTACHED;
            else if (hreset && !operate)
                state_q <= PDCR_ST_ATTACHED;
            else
            begin
                unique case (state_q)
                    PDCR_ST_ATTACHED:
                        if (contract && operate)
                            state_q <= PDCR_ST_POWERED;
                    PDCR_ST_POWERED:
                        if (bus_reset_in)
                            state_q <= PDCR_ST_DEFAULT;
                    PDCR_ST_DEFAULT:
                        if (addressed_in)
                            state_q <= PDCR_ST_ADDRESS;
                    PDCR_ST_ADDRESS:
                        if (bus_reset_in)
                            state_q <= PDCR_ST_DEFAULT;
                        else if (configured_in)
                            state_q <= PDCR_ST_CONFIGURED;
                    PDCR_ST_CONFIGURED:
                        if (bus_reset_in)
                            state_q <= PDCR_ST_DEFAULT;
                        else if (!configured_in)
                            state_q <= PDCR_ST_ADDRESS;
                    default:
                        state_q <= PDCR_ST_ATTACHED;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            connect_out      <= 1'b0;
            self_powered_out <= 1'b0;
            usb_state_out    <= 3'h0;
        end
        else if (ce_in)
        begin
            // Connect only once a contract is held, never on bus alone
            connect_out      <= (state_q != PDCR_ST_ATTACHED);
            self_powered_out <= 1'b1;
            usb_state_out    <= state_q;
        end
    end

    // Policy mode: local always, others only when built in
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
            policy_mode_out <= PDCR_MODE_LOCAL;
        else if (ce_in && req_valid_in && req_sel_in == PDCR_SEL_STATUS)
        begin
            if (policy_mode_in == PDCR_MODE_HYBRID && HAS_HYBRID)
                policy_mode_out <= PDCR_MODE_HYBRID;
            else if (policy_mode_in == PDCR_MODE_INTRUSIVE && HAS_INTRUSIVE)
                policy_mode_out <= PDCR_MODE_INTRUSIVE;
            else
                policy_mode_out <= PDCR_MODE_LOCAL;
        end
    end

    // Request server: one byte per cycle, last marked
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rd_q          <= PDCR_RD_IDLE;
            ptr_q         <= 8'h00;
            len_q         <= 8'h00;
            sel_q         <= PDCR_SEL_SET;
            idx_q         <= 8'h00;
            rsp_valid_out <= 1'b0;
            rsp_data_out  <= 8'h00;
            rsp_last_out  <= 1'b0;
            rsp_stall_out <= 1'b0;
        end
        else if (ce_in)
        begin
            rsp_valid_out <= 1'b0;
            rsp_last_out  <= 1'b0;
            rsp_stall_out <= 1'b0;
            unique case (rd_q)
                PDCR_RD_IDLE:
                    if (req_valid_in)
                    begin
                        sel_q <= req_sel_in;
                        idx_q <= req_index_in;
                        ptr_q <= 8'h00;
                        // Port query exists on hubs only, in range
                        if (req_sel_in == PDCR_SEL_PORT &&
                            (!IS_HUB || req_index_in >= 8'(NUM_PORTS)))
                            rsp_stall_out <= 1'b1;
                        else if (req_sel_in == 2'h3)
                            rsp_stall_out <= 1'b1;
                        else
                        begin
                            rd_q  <= PDCR_RD_SEND;
                            len_q <= (req_sel_in == PDCR_SEL_SET) ?
                                     total_len() : 8'h02;
                        end
                    end
                PDCR_RD_SEND:
                begin
                    rsp_valid_out <= 1'b1;
                    unique case (sel_q)
                        PDCR_SEL_SET:
                            rsp_data_out <= set_byte(ptr_q);
                        PDCR_SEL_STATUS:
                            rsp_data_out <= (ptr_q == 8'h00) ?
                                {3'h0, contract_q, vbus, state_q} :
                                {6'h0, policy_mode_out};
                        default:
                            rsp_data_out <= (ptr_q == 8'h00) ?
                                {7'h0, port_q[idx_q[PW-1:0]]} :
                                8'h00;
                    endcase
                    ptr_q <= ptr_q + 8'h01;
                    if (ptr_q == len_q - 8'h01)
                    begin
                        rsp_last_out <= 1'b1;
                        rd_q         <= PDCR_RD_DONE;
                    end
                end
                PDCR_RD_DONE:
                    rd_q <= PDCR_RD_IDLE;
                default:
                    rd_q <= PDCR_RD_IDLE;
            endcase
        end
    end

    // On hubs, notifications on contract or port change (contract wins a tie), held until taken; a newer event replaces the id
    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            contract_q     <= 1'b0;
            port_q         <= '0;
            note_valid_out <= 1'b0;
            note_data_out  <= 8'h00;
        end
        else if (ce_in)
        begin
            contract_q <= contract;
            port_q     <= port_pd_in;
            if (note_valid_out && note_ready_in)
                note_valid_out <= 1'b0;
            // A new event wins over the take of the previous one
            if (IS_HUB && contract != contract_q)
            begin
                note_valid_out <= 1'b1;
                note_data_out  <= PDCR_NOTE_CONTRACT;
            end
            else if (IS_HUB && port_pd_in != port_q)
            begin
                note_valid_out <= 1'b1;
                note_data_out  <= PDCR_NOTE_PORT;
            end
        end
    end

endmodule

// *** verification/pdcr_props.sv ***
// Assertion checker for the power capability report block
`timescale 1ns/1ps
module pdcr_props
    import pdcr_pkg::*;
#(
    parameter int NUM_PORTS  = 4,
    parameter bit HAS_HYBRID = 1'b0
)
(
    input  wire logic       clk_sys_in,
    input  wire logic       nrst_in,
    input  wire logic       ce_in,
    input  wire logic       contract_ok_in,
    input  wire logic       can_operate_in,
    input  wire logic       req_valid_in,
    input  wire logic [1:0] req_sel_in,
    input  wire logic [7:0] req_index_in,
    input  wire logic       note_ready_in,
    input  wire logic       connect_out,
    input  wire logic       self_powered_out,
    input  wire logic [2:0] usb_state_out,
    input  wire logic       rsp_valid_out,
    input  wire logic [7:0] rsp_data_out,
    input  wire logic       rsp_last_out,
    input  wire logic       rsp_stall_out,
    input  wire logic [1:0] policy_mode_out,
    input  wire logic       note_valid_out
);
    logic busy_q;
    logic last_q;
    // Mirrors the idle rule so only requests the server takes arm a check
    wire  take = ce_in && req_valid_in && !busy_q && !last_q;

    always_ff @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            busy_q <= 1'b0;
            last_q <= 1'b0;
        end
        else
        begin
            last_q <= rsp_last_out;
            if (take)
                busy_q <= 1'b1;
            else if (rsp_stall_out || rsp_last_out)
                busy_q <= 1'b0;
        end
    end

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    sequence s_take(logic [1:0] sel);
        take && req_sel_in == sel;
    endsequence
    sequence s_port_ok;
        s_take(PDCR_SEL_PORT) ##0 req_index_in < NUM_PORTS;
    endsequence
    sequence s_port_bad;
        s_take(PDCR_SEL_PORT) ##0 req_index_in >= NUM_PORTS;
    endsequence

    property p_set_hdr;
        s_take(PDCR_SEL_SET) |-> ##2 rsp_valid_out &&
            rsp_data_out == PDCR_SET_HDR_LEN ##1 rsp_data_out == PDCR_SET_TYPE;
    endproperty
    a_set_hdr: assert property (p_set_hdr)
        else $error("object store header bytes wrong");
    property p_status;
        s_take(PDCR_SEL_STATUS) |-> ##2 rsp_valid_out && !rsp_last_out
            ##1 rsp_valid_out && rsp_last_out;
    endproperty
    a_status: assert property (p_status)
        else $error("status answer not two bytes");
    property p_port_ok;
        s_port_ok |-> ##2 rsp_valid_out && rsp_data_out[7:1] == 7'h00
            ##1 rsp_last_out && rsp_data_out == 8'h00;
    endproperty
    a_port_ok: assert property (p_port_ok)
        else $error("port answer wrong");
    property p_port_bad;
        s_port_bad |-> ##1 rsp_stall_out && !rsp_valid_out;
    endproperty
    a_port_bad: assert property (p_port_bad)
        else $error("bad port index not stalled");
    property p_stall;
        s_take(2'h3) |-> ##1 rsp_stall_out;
    endproperty
    a_stall: assert property (p_stall)
        else $error("unknown selector not stalled");
    property p_connect;
        // Both outputs load from the same state flop on the same edge
        connect_out == (usb_state_out != 3'h0);
    endproperty
    a_connect: assert property (p_connect)
        else $error("connect does not follow state");
    property p_self;
        // Sampled reset keeps the release edge itself out of the check
        nrst_in && ce_in |=> self_powered_out;
    endproperty
    a_self: assert property (p_self)
        else $error("not reported self powered");
    property p_powered;
        $rose(usb_state_out == 3'h1) |->
            $past(contract_ok_in, 3) && $past(can_operate_in, 3);
    endproperty
    a_powered: assert property (p_powered)
        else $error("powered without contract");
    property p_note;
        note_valid_out && !note_ready_in |=> note_valid_out;
    endproperty
    a_note: assert property (p_note)
        else $error("notification dropped before taken");
    property p_mode;
        policy_mode_out != PDCR_MODE_HYBRID || HAS_HYBRID;
    endproperty
    a_mode: assert property (p_mode)
        else $error("unsupported mode in force");
endmodule

bind pdcr_top pdcr_props #(.NUM_PORTS(NUM_PORTS), .HAS_HYBRID(HAS_HYBRID))
    i_pdcr_props (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .ce_in(ce_in), .contract_ok_in(contract_ok_in),
    .can_operate_in(can_operate_in), .req_valid_in(req_valid_in),
    .req_sel_in(req_sel_in), .req_index_in(req_index_in),
    .note_ready_in(note_ready_in), .connect_out(connect_out),
    .self_powered_out(self_powered_out), .usb_state_out(usb_state_out),
    .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
    .rsp_last_out(rsp_last_out), .rsp_stall_out(rsp_stall_out),
    .policy_mode_out(policy_mode_out), .note_valid_out(note_valid_out));

// *** verification/pdcr_host_model.sv ***
// Host side model that drains the hub notification endpoint
`timescale 1ns/1ps
module pdcr_host_model
(
    input  wire logic       clk_sys_in,
    input  wire logic       nrst_in,
    input  wire logic       slow_in,
    input  wire logic       note_valid_in,
    input  wire logic [7:0] note_data_in,
    output logic            note_ready_out,
    output logic [7:0]      note_last_out,
    output int              note_cnt_out
);
    always @(posedge clk_sys_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            note_ready_out <= 1'b0;
            note_last_out  <= 8'h00;
            note_cnt_out   <= 0;
        end
        else
        begin
            // Random stalls make a pending notification wait
            note_ready_out <= slow_in ? 1'($urandom_range(1)) : 1'b1;
            if (note_valid_in === 1'b1 && note_ready_out)
            begin
                note_last_out <= note_data_in;
                note_cnt_out  <= note_cnt_out + 1;
            end
        end
    end
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the power capability report block
`timescale 1ns/1ps
module testbench
    import pdcr_pkg::*;
;
    localparam int NP = 4;
    logic       clk = 1'b0, nrst = 1'b0, vbus = 1'b0, contract = 1'b0;
    logic       operate = 1'b0, swap = 1'b0, hreset = 1'b0, bus_rst = 1'b0;
    logic       addr = 1'b0, cfg = 1'b0, req_v = 1'b0, slow = 1'b0, ce = 1'b1;
    logic [1:0] req_sel = 2'h0, mode = 2'h0;
    logic [7:0] req_idx = 8'h00;
    logic [NP-1:0] port_pd = '0;
    logic       note_ready, connect, self_pw, rsp_v, rsp_last, rsp_stall;
    logic       note_v, got_stall;
    logic [2:0] state;
    logic [1:0] pol_mode;
    logic [7:0] rsp_d, note_d, note_last, idx;
    logic [7:0] rx[$];
    logic [NP-1:0] pd;
    logic [2:0] found;
    int         failures = 0, checked = 0, note_cnt;

    always #25 clk = ~clk;

    pdcr_top #(.NUM_PORTS(NP)) i_pdcr_top (.clk_sys_in(clk),
        .nrst_in(nrst), .ce_in(ce), .vbus_present_in(vbus),
        .contract_ok_in(contract), .can_operate_in(operate),
        .role_swap_in(swap), .hard_reset_in(hreset), .bus_reset_in(bus_rst),
        .addressed_in(addr), .configured_in(cfg), .req_valid_in(req_v),
        .req_sel_in(req_sel), .req_index_in(req_idx),
        .policy_mode_in(mode), .port_pd_in(port_pd),
        .note_ready_in(note_ready), .connect_out(connect),
        .self_powered_out(self_pw), .usb_state_out(state),
        .rsp_valid_out(rsp_v), .rsp_data_out(rsp_d),
        .rsp_last_out(rsp_last), .rsp_stall_out(rsp_stall),
        .policy_mode_out(pol_mode), .note_valid_out(note_v),
        .note_data_out(note_d));

    pdcr_host_model i_pdcr_host_model (.clk_sys_in(clk), .nrst_in(nrst),
        .slow_in(slow), .note_valid_in(note_v), .note_data_in(note_d),
        .note_ready_out(note_ready), .note_last_out(note_last),
        .note_cnt_out(note_cnt));

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One request, then collect bytes or a stall; spacing kept legal
    task automatic ask(input logic [1:0] sel, input logic [7:0] ix,
                       input logic [1:0] md);
        rx.delete();
        got_stall = 1'b0;
        @(posedge clk);
        req_v   <= 1'b1;
        req_sel <= sel;
        req_idx <= ix;
        mode    <= md;
        @(posedge clk);
        req_v <= 1'b0;
        for (int k = 0; k < 80; k++)
        begin
            @(negedge clk);
            if (rsp_stall === 1'b1)
                got_stall = 1'b1;
            if (rsp_v === 1'b1)
                rx.push_back(rsp_d);
            if (rsp_last === 1'b1 || rsp_stall === 1'b1)
                break;
        end
        cyc(3);
    endtask

    function automatic logic [31:0] exp_attr();
        // Type-C, consumer, power delivery and charging bits of the defaults
        return {25'h0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    endfunction

    function automatic logic [7:0] exp_status(input logic [2:0] s);
        return {3'b000, 1'b1, 1'b1, s};
    endfunction

    initial
    begin
        void'($urandom(32'h35e6));
        cyc(16);
        nrst <= 1'b1;
        cyc(2);
        chk("self powered", self_pw, 1);
        vbus <= 1'b1;
        cyc(10);
        chk("bus only", state, PDCR_ST_ATTACHED);
        operate <= 1'b1;
        cyc(10);
        chk("no contract", connect, 0);
        contract <= 1'b1;
        cyc(10);
        chk("contract", state, PDCR_ST_POWERED);
        chk("connect", connect, 1);
        chk("contract note", note_last, PDCR_NOTE_CONTRACT);
        chk("note count", note_cnt, 1);
        bus_rst <= 1'b1;
        cyc(1);
        bus_rst <= 1'b0;
        cyc(3);
        chk("default", state, PDCR_ST_DEFAULT);
        addr <= 1'b1;
        cyc(3);
        chk("address", state, PDCR_ST_ADDRESS);
        cfg <= 1'b1;
        cyc(3);
        chk("configured", state, PDCR_ST_CONFIGURED);
        // Enable low must hold the state through a dropped configuration
        ce  <= 1'b0;
        cfg <= 1'b0;
        cyc(4);
        chk("frozen", state, PDCR_ST_CONFIGURED);
        ce  <= 1'b1;
        cfg <= 1'b1;
        ask(PDCR_SEL_SET, 8'h00, PDCR_MODE_LOCAL);
        chk("set size", rx.size(), 53);
        chk("hdr", {rx[0], rx[1], rx[2], rx[3]}, 32'h050f3500);
        chk("cap", {rx[5], rx[6], rx[7], rx[8]}, 32'h18100600);
        chk("attr", {rx[12], rx[11], rx[10], rx[9]}, exp_attr());
        chk("rsvd", {rx[12], rx[11], rx[10], rx[9]} & PDCR_ATTR_RSVD_MASK,
            0);
        found = 3'b000;
        for (int r = 29; r + 2 < rx.size(); r += 8)
            found |= {rx[r+2] == 8'h07, rx[r+2] == 8'h09, rx[r+2] == 8'h08};
        chk("record codes", found, 3'b111);
        for (int m = 0; m < 3; m++)
        begin
            ask(PDCR_SEL_STATUS, 8'h00, 2'(m));
            chk("status", {rx[0], rx[1]},
                {exp_status(PDCR_ST_CONFIGURED), 8'h00});
            chk("mode", pol_mode, PDCR_MODE_LOCAL);
        end
        ask(2'h3, 8'h00, PDCR_MODE_LOCAL);
        chk("sel stall", {got_stall, 8'(rx.size())}, 9'h100);
        slow <= 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            pd = NP'($urandom);
            port_pd <= pd;
            cyc(2);
            idx = (i == 0) ? 8'd3 : (i == 1) ? 8'd4 : 8'($urandom_range(5));
            ask(PDCR_SEL_PORT, idx, PDCR_MODE_LOCAL);
            if (idx < NP)
                chk("port", {rx[0], rx[1]}, {7'h00, pd[idx], 8'h00});
            else
                chk("port stall", got_stall, 1);
        end
        cyc(40);
        chk("port note", note_last, PDCR_NOTE_PORT);
        chk("drained", note_v, 0);
        swap <= 1'b1;
        vbus <= 1'b0;
        cyc(10);
        chk("swap keeps", state === PDCR_ST_ATTACHED, 0);
        swap <= 1'b0;
        addr <= 1'b0;
        cfg  <= 1'b0;
        cyc(10);
        chk("bus lost", {state, connect}, {PDCR_ST_ATTACHED, 1'b0});
        vbus <= 1'b1;
        cyc(10);
        chk("back", state, PDCR_ST_POWERED);
        hreset  <= 1'b1;
        operate <= 1'b0;
        cyc(10);
        chk("hard reset", state, PDCR_ST_ATTACHED);
        test_done();
    end

    initial
    begin
        #(50 * 20000);
        failures++;
        test_done();
    end
endmodule
